//--- rtl/gsri_consts.vh
/*
 * register offsets, reset values, frame fields and timing counts for the gyro
 * spi register interface. assumes inclusion by bare name from design files.
 */
`ifndef GSRI_CONSTS_VH
`define GSRI_CONSTS_VH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define GSRI_FRAME_BITS      5'd16
`define GSRI_WR_BIT          15
`define GSRI_ADDR_HI         14
`define GSRI_ADDR_LO         8

// ---------------------------------------------------------------
// lower-byte register offsets
// ---------------------------------------------------------------
`define GSRI_FLASH_WRITE_COUNTER_ADDR  7'h00
`define GSRI_SUPPLY_ADDR     7'h02
`define GSRI_RATE_ADDR       7'h04
`define GSRI_ANALOG_IN_ADDR  7'h0a
`define GSRI_TEMP_ADDR       7'h0c
`define GSRI_ANGLE_ADDR      7'h0e
`define GSRI_RATE_OFF_ADDR   7'h14
`define GSRI_RATE_SCL_ADDR   7'h16
`define GSRI_ALM1_MAG_ADDR   7'h20
`define GSRI_ALM2_MAG_ADDR   7'h22
`define GSRI_ALM1_PRD_ADDR   7'h24
`define GSRI_ALM2_PRD_ADDR   7'h26
`define GSRI_ALARM_CONTROL_ADDR   7'h28
`define GSRI_DAC_ADDR        7'h30
`define GSRI_DLINE_ADDR      7'h32
`define GSRI_MISC_ADDR       7'h34
`define GSRI_SMPL_ADDR       7'h36
`define GSRI_RANGE_ADDR      7'h38
`define GSRI_SLEEP_ADDR      7'h3a
`define GSRI_DIAG_ADDR       7'h3c
`define GSRI_GCMD_ADDR       7'h3e
`define GSRI_LOT1_ADDR       7'h52
`define GSRI_LOT2_ADDR       7'h54
`define GSRI_PART_ADDR       7'h56
`define GSRI_SERIAL_ADDR     7'h58

// ---------------------------------------------------------------
// working copy index (flash-backed slots first)
// ---------------------------------------------------------------
`define GSRI_NSLOT           4'd13
`define GSRI_SL_RATE_OFF     4'd0
`define GSRI_SL_RATE_SCL     4'd1
`define GSRI_SL_ALM1_MAG     4'd2
`define GSRI_SL_ALM2_MAG     4'd3
`define GSRI_SL_ALM1_PRD     4'd4
`define GSRI_SL_ALM2_PRD     4'd5
`define GSRI_SL_ALARM_CONTROL     4'd6
`define GSRI_SL_MISC         4'd7
`define GSRI_SL_SMPL         4'd8
`define GSRI_SL_RANGE        4'd9
`define GSRI_SL_SLEEP        4'd10
`define GSRI_SL_DAC          4'd11
`define GSRI_SL_DLINE        4'd12
`define GSRI_NFLASH          4'd11

// ---------------------------------------------------------------
// reset values and command bits
// ---------------------------------------------------------------
`define GSRI_RST_RATE_SCL    16'h0800
`define GSRI_RST_SMPL        16'h0001
`define GSRI_RST_RANGE       16'h0402
`define GSRI_RST_ZERO        16'h0000
`define GSRI_PART_CODE       16'h5a5a
`define GSRI_CMD_NULL_BIT    0
`define GSRI_CMD_SAVE_BIT    3
`define GSRI_DRDY_LO         0
`define GSRI_DRDY_HI         2
`define GSRI_ND_BIT          15
`define GSRI_EA_BIT          14

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define GSRI_CLK_NS          4
`define GSRI_DRDY_NS         40
`define GSRI_DRDY_CYC        4'd10

`endif

//--- rtl/gsri_pin_sync.v
/*
 * three-flop synchroniser with agreement filter for one pin.
 * assumes clk_in is the block clock and pin_in is asynchronous to it.
 */
`timescale 1ns/1ps

module gsri_pin_sync
(
    input  wire clk_in,
    input  wire rst_in,
    input  wire pin_in,
    input  wire rst_val_in,
    output reg  level_out
);
    reg s1;
    reg s2;
    reg s3;

    // ---------------------------------------------------------------
    // capture chain
    // ---------------------------------------------------------------
    // s1 feeds only s2, avoiding metastable fan-out
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            // start at the pin's idle level so no false edge follows reset
            s1        <= rst_val_in;
            s2        <= rst_val_in;
            s3        <= rst_val_in;
            level_out <= rst_val_in;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level_out <= s3;
        end
    end
endmodule // gsri_pin_sync

//--- rtl/gsri_top.v
/*
 * spi slave and user register map of a gyroscope sensor: frame shifter,
 * working copies with flash backup, command decode and pipelined reads.
 * assumes the spi pins are asynchronous and sampled on ref_clk_in; the
 * sensor datapath delivers measurement words on the meas_* ports.
 */
`timescale 1ns/1ps
`include "gsri_consts.vh"

// How it works
// - input sampled on serial clock rise, output changed on fall.
// - mode 3, msb first, sixteen-bit frames, device is slave only.
// - full duplex: response shifts out while next command shifts in.
// - each sixteen-bit register answers two seven-bit byte addresses.
// - upper byte sits at lower byte address plus one.
// - a write frame changes at most one register byte; command and read-only addresses change none.
// - write commands act right after the sixteenth rising edge.
// - command bit 0 starts the bias null sequence.
// - command bit 3 copies working copies 0..10 into flash storage.
// - working copies take writes; slots 0..10 loaded from flash after reset, dac and dline cleared.
// - read is two frames: command, then returned register data.
// - read at either byte address returns the full register.
// - read command in data frame picks the next returned register.
// - device runs autonomously, loading results into output registers.
// - read-only flash write counter at address 0x00.
// - read-only part code register at address 0x56.
// - misc control bits 2..0 make a digital line data ready.
// - msb out on chip select fall; output released after frame.
// - outputs carry new-data flag and error flag bits.
module gsri_top
(
    input  wire        ref_clk_in,
    input  wire        sys_rst_in,
    input  wire        spi_clk_in,
    input  wire        spi_sel_n_in,
    input  wire        spi_din_in,
    output reg         spi_dout_out,
    output reg         spi_dout_oe_out,
    input  wire        dev_rst_n_in,
    input  wire [15:0] meas_supply_in,
    input  wire [15:0] meas_rate_in,
    input  wire [15:0] meas_analog_in,
    input  wire [15:0] meas_temp_in,
    input  wire [15:0] meas_angle_in,
    input  wire [15:0] meas_diag_in,
    input  wire        meas_valid_in,
    input  wire [15:0] lot1_in,
    input  wire [15:0] lot2_in,
    input  wire [15:0] serial_in,
    output reg         null_start_out,
    output reg         angle_wr_out,
    output reg  [15:0] angle_wr_data_out,
    output reg         digital_line_1_out,
    output reg         digital_line_1_oe_out,
    output reg         digital_line_2_out,
    output reg         digital_line_2_oe_out,
    output reg  [15:0] sample_period_out,
    output reg  [15:0] range_and_filter_control_out,
    output reg  [15:0] misc_control_out,
    output reg         ready_out
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    localparam ST_LOAD = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_SAVE = 3'b100;

    wire        sclk_s;
    wire        sel_n_s;
    wire        din_s;
    wire        rstn_s;
    reg         sclk_d;
    reg         sel_d;
    reg         reload_q;
    reg  [15:0] rx_sh;
    reg  [15:0] tx_sh;
    reg  [4:0]  bit_cnt;
    reg  [6:0]  rd_addr;
    reg  [15:0] work [0:12];
    reg  [15:0] flash [0:10];
    reg  [15:0] flash_write_counter;
    reg  [15:0] supply_r;
    reg  [15:0] rate_r;
    reg  [15:0] analog_r;
    reg  [15:0] temp_r;
    reg  [15:0] diag_r;
    reg  [15:0] angle_r;
    reg  [4:0]  unread;
    reg  [2:0]  state;
    reg  [3:0]  idx;
    reg  [3:0]  drdy_cnt;
    reg         flash_init;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        sel_fall;
    wire        frame_done;
    wire [15:0] frame;
    wire        dev_rst;
    reg  [15:0] rd_word;
    integer     i;
    integer     j;

    // map a byte address to a working-copy slot; 4'hf when none
    function [3:0] slot_of;
        input [6:0] a;
        begin
            case ({a[6:1], 1'b0})
                `GSRI_RATE_OFF_ADDR: slot_of = `GSRI_SL_RATE_OFF;
                `GSRI_RATE_SCL_ADDR: slot_of = `GSRI_SL_RATE_SCL;
                `GSRI_ALM1_MAG_ADDR: slot_of = `GSRI_SL_ALM1_MAG;
                `GSRI_ALM2_MAG_ADDR: slot_of = `GSRI_SL_ALM2_MAG;
                `GSRI_ALM1_PRD_ADDR: slot_of = `GSRI_SL_ALM1_PRD;
                `GSRI_ALM2_PRD_ADDR: slot_of = `GSRI_SL_ALM2_PRD;
                `GSRI_ALARM_CONTROL_ADDR: slot_of = `GSRI_SL_ALARM_CONTROL;
                `GSRI_MISC_ADDR:     slot_of = `GSRI_SL_MISC;
                `GSRI_SMPL_ADDR:     slot_of = `GSRI_SL_SMPL;
                `GSRI_RANGE_ADDR:    slot_of = `GSRI_SL_RANGE;
                `GSRI_SLEEP_ADDR:    slot_of = `GSRI_SL_SLEEP;
                `GSRI_DAC_ADDR:      slot_of = `GSRI_SL_DAC;
                `GSRI_DLINE_ADDR:    slot_of = `GSRI_SL_DLINE;
                default:             slot_of = 4'hf;
            endcase
        end
    endfunction

    // factory value of a working copy, used to seed blank flash
    function [15:0] dflt_of;
        input [3:0] s;
        begin
            case (s)
                `GSRI_SL_RATE_SCL: dflt_of = `GSRI_RST_RATE_SCL;
                `GSRI_SL_SMPL:     dflt_of = `GSRI_RST_SMPL;
                `GSRI_SL_RANGE:    dflt_of = `GSRI_RST_RANGE;
                default:           dflt_of = `GSRI_RST_ZERO;
            endcase
        end
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    gsri_pin_sync u_sclk (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .pin_in(spi_clk_in),
                          .rst_val_in(1'b1), .level_out(sclk_s));
    gsri_pin_sync u_sel  (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .pin_in(spi_sel_n_in),
                          .rst_val_in(1'b1), .level_out(sel_n_s));
    gsri_pin_sync u_din  (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .pin_in(spi_din_in),
                          .rst_val_in(1'b1), .level_out(din_s));
    gsri_pin_sync u_rst  (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .pin_in(dev_rst_n_in),
                          .rst_val_in(1'b1), .level_out(rstn_s));

    // mode 3: idle high, so a rise samples and a fall shifts
    assign sclk_rise  = ~sclk_d & sclk_s & ~sel_n_s;
    assign sclk_fall  = sclk_d & ~sclk_s & ~sel_n_s;
    assign sel_fall   = sel_d & ~sel_n_s;
    assign frame      = {rx_sh[14:0], din_s};
    assign frame_done = sclk_rise && (bit_cnt == `GSRI_FRAME_BITS - 5'd1);
    assign dev_rst    = ~rstn_s;

    // ---------------------------------------------------------------
    // read mux, full register at either byte address
    // ---------------------------------------------------------------
    always @*
    begin
        rd_word = `GSRI_RST_ZERO;                                   // reserved reads zero
        case ({rd_addr[6:1], 1'b0})
            `GSRI_FLASH_WRITE_COUNTER_ADDR: rd_word = flash_write_counter;
            `GSRI_SUPPLY_ADDR:    rd_word = {unread[0], diag_r != 16'h0000, supply_r[13:0]};
            `GSRI_RATE_ADDR:      rd_word = {unread[1], diag_r != 16'h0000, rate_r[13:0]};
            `GSRI_ANALOG_IN_ADDR: rd_word = {unread[2], diag_r != 16'h0000, analog_r[13:0]};
            `GSRI_TEMP_ADDR:      rd_word = {unread[3], diag_r != 16'h0000, temp_r[13:0]};
            `GSRI_ANGLE_ADDR:     rd_word = {unread[4], diag_r != 16'h0000, angle_r[13:0]};
            `GSRI_DIAG_ADDR:      rd_word = diag_r;
            `GSRI_LOT1_ADDR:      rd_word = lot1_in;
            `GSRI_LOT2_ADDR:      rd_word = lot2_in;
            `GSRI_PART_ADDR:      rd_word = `GSRI_PART_CODE;
            `GSRI_SERIAL_ADDR:    rd_word = serial_in;
            default:
                if (slot_of(rd_addr) != 4'hf)
                    rd_word = work[slot_of(rd_addr)];
        endcase
    end

    // ---------------------------------------------------------------
    // serial shifter
    // ---------------------------------------------------------------
    // dout released whenever chip select is high
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in || dev_rst)
        begin
            sclk_d          <= 1'b1;
            sel_d           <= 1'b1;
            reload_q        <= 1'b0;
            rx_sh           <= 16'h0000;
            tx_sh           <= 16'h0000;
            bit_cnt         <= 5'd0;
            rd_addr         <= 7'h00;
            spi_dout_out    <= 1'b0;
            spi_dout_oe_out <= 1'b0;
        end
        else
        begin
            sclk_d   <= sclk_s;
            sel_d    <= sel_n_s;
            reload_q <= frame_done;
            if (sel_n_s)
            begin
                bit_cnt         <= 5'd0;
                spi_dout_oe_out <= 1'b0;
            end
            else if (sel_fall || reload_q)
            begin
                // back-to-back frames reload a cycle after the new address lands
                tx_sh           <= {rd_word[14:0], 1'b0};
                spi_dout_out    <= rd_word[15];
                spi_dout_oe_out <= 1'b1;
            end
            else
            begin
                // first fall keeps the msb, else the master's first rise loses it
                if (sclk_fall && bit_cnt != 5'd0)
                begin
                    spi_dout_out <= tx_sh[15];
                    tx_sh        <= {tx_sh[14:0], 1'b0};
                end
                if (sclk_rise)
                begin
                    rx_sh   <= frame;                               // msb first
                    bit_cnt <= frame_done ? 5'd0 : bit_cnt + 5'd1;
                    if (frame_done && !frame[`GSRI_WR_BIT])
                        rd_addr <= frame[`GSRI_ADDR_HI:`GSRI_ADDR_LO];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // working copies, flash image, commands
    // ---------------------------------------------------------------
    // flash survives device reset; only sys reset blanks it to defaults
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            flash_init <= 1'b0;
            flash_write_counter  <= 16'h0000;
            for (i = 0; i < 11; i = i + 1)
                flash[i] <= 16'h0000;
        end
        else
        begin
            if (!flash_init)
            begin
                flash_init <= 1'b1;
                for (i = 0; i < 11; i = i + 1)
                    flash[i] <= dflt_of(i[3:0]);
            end
            else if (state == ST_SAVE)
            begin
                for (i = 0; i < 11; i = i + 1)
                    flash[i] <= work[i];
                flash_write_counter <= flash_write_counter + 16'h0001;
            end
        end
    end

    // load, run, save sequencing
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in || dev_rst || !flash_init)
        begin
            state          <= ST_LOAD;
            idx            <= 4'd0;
            null_start_out <= 1'b0;
            angle_wr_out   <= 1'b0;
            angle_wr_data_out <= 16'h0000;
            ready_out      <= 1'b0;
            for (j = 0; j < 13; j = j + 1)
                work[j] <= 16'h0000;
        end
        else
        begin
            null_start_out <= 1'b0;
            angle_wr_out   <= 1'b0;
            case (state)
                ST_LOAD:
                begin
                    if (idx < `GSRI_NFLASH)
                        work[idx] <= flash[idx];
                    if (idx == `GSRI_NSLOT - 4'd1)
                    begin
                        state     <= ST_RUN;
                        ready_out <= 1'b1;                          // data after load
                    end
                    idx <= idx + 4'd1;
                end
                ST_RUN:
                begin
                    if (frame_done && frame[`GSRI_WR_BIT])
                    begin
                        // one byte per frame, odd address hits upper byte
                        if (slot_of(frame[14:8]) != 4'hf)
                        begin
                            if (frame[8])
                                work[slot_of(frame[14:8])][15:8] <= frame[7:0];
                            else
                                work[slot_of(frame[14:8])][7:0] <= frame[7:0];
                        end
                        else if ({frame[14:9], 1'b0} == `GSRI_ANGLE_ADDR)
                        begin
                            angle_wr_out      <= 1'b1;
                            angle_wr_data_out <= frame[8] ? {frame[7:0], angle_r[7:0]}
                                                          : {angle_r[15:8], frame[7:0]};
                        end
                        else if (frame[14:8] == `GSRI_GCMD_ADDR)
                        begin
                            null_start_out <= frame[`GSRI_CMD_NULL_BIT];
                            if (frame[`GSRI_CMD_SAVE_BIT])
                                state <= ST_SAVE;
                        end
                    end
                end
                ST_SAVE:
                    state <= ST_RUN;
                default:
                    state <= ST_LOAD;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // output registers and data ready
    // ---------------------------------------------------------------
    // new-data flags clear once the word is shifted out in a read frame; a fresh sample wins
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in || dev_rst)
        begin
            supply_r <= 16'h0000;
            rate_r   <= 16'h0000;
            analog_r <= 16'h0000;
            temp_r   <= 16'h0000;
            angle_r  <= 16'h0000;
            diag_r   <= 16'h0000;
            unread   <= 5'b00000;
            drdy_cnt <= 4'd0;
        end
        else
        begin
            // flag of the word just shifted out in a read frame clears; a sample below wins
            if (frame_done && !frame[`GSRI_WR_BIT])
            begin
                case ({rd_addr[6:1], 1'b0})
                    `GSRI_SUPPLY_ADDR:    unread[0] <= 1'b0;
                    `GSRI_RATE_ADDR:      unread[1] <= 1'b0;
                    `GSRI_ANALOG_IN_ADDR: unread[2] <= 1'b0;
                    `GSRI_TEMP_ADDR:      unread[3] <= 1'b0;
                    `GSRI_ANGLE_ADDR:     unread[4] <= 1'b0;
                    default:              unread    <= unread;
                endcase
            end
            if (angle_wr_out)
                angle_r <= angle_wr_data_out;
            if (meas_valid_in && ready_out)
            begin
                supply_r <= meas_supply_in;
                rate_r   <= meas_rate_in;
                analog_r <= meas_analog_in;
                temp_r   <= meas_temp_in;
                angle_r  <= meas_angle_in;
                diag_r   <= meas_diag_in;
                unread   <= 5'b11111;
                drdy_cnt <= `GSRI_DRDY_CYC;
            end
            else if (drdy_cnt != 4'd0)
                drdy_cnt <= drdy_cnt - 4'd1;
        end
    end

    // data-ready line, pulse held at the level of misc bit 1 for a short fixed time
    always @(posedge ref_clk_in)
    begin
        if (sys_rst_in || dev_rst)
        begin
            digital_line_1_out    <= 1'b1;
            digital_line_1_oe_out <= 1'b0;
            digital_line_2_out    <= 1'b1;
            digital_line_2_oe_out <= 1'b0;
            sample_period_out     <= 16'h0000;
            range_and_filter_control_out <= 16'h0000;
            misc_control_out      <= 16'h0000;
        end
        else
        begin
            // bit 2 enables, bit 1 polarity, bit 0 picks the line
            digital_line_1_oe_out <= work[`GSRI_SL_MISC][2] & ~work[`GSRI_SL_MISC][0];
            digital_line_2_oe_out <= work[`GSRI_SL_MISC][2] & work[`GSRI_SL_MISC][0];
            digital_line_1_out    <= (drdy_cnt != 4'd0) ^ ~work[`GSRI_SL_MISC][1];
            digital_line_2_out    <= (drdy_cnt != 4'd0) ^ ~work[`GSRI_SL_MISC][1];
            sample_period_out     <= work[`GSRI_SL_SMPL];
            range_and_filter_control_out <= work[`GSRI_SL_RANGE];
            misc_control_out      <= work[`GSRI_SL_MISC];
        end
    end
endmodule // gsri_top

//--- test/gsri_monitor.sv
/* port assertions for the gyro spi register block.
   assumes binding into gsri_top, all checks on ref_clk_in. */
`timescale 1ns/1ps
module gsri_monitor
(
    input wire        ref_clk_in,
    input wire        sys_rst_in,
    input wire        spi_clk_in,
    input wire        spi_sel_n_in,
    input wire        dev_rst_n_in,
    input wire        spi_dout_out,
    input wire        spi_dout_oe_out,
    input wire        null_start_out,
    input wire        angle_wr_out,
    input wire        digital_line_2_oe_out,
    input wire [15:0] sample_period_out,
    input wire [15:0] misc_control_out,
    input wire        ready_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // pin patterns long enough to outlast the synchroniser latency
    sequence deselected; spi_sel_n_in [*8]; endsequence
    sequence selected; !spi_sel_n_in [*8]; endsequence
    sequence clk_high;
        (spi_clk_in && !spi_sel_n_in && !$past(spi_sel_n_in, 5)) [*4];
    endsequence
    sequence quiet; (spi_sel_n_in && ready_out && dev_rst_n_in) [*8]; endsequence
    oe_idle_a: assert property (deselected |-> !spi_dout_oe_out)
        else $error("dout driven while deselected");
    oe_drive_a: assert property (selected |-> spi_dout_oe_out)
        else $error("dout not driven while selected");
    dout_hold_a: assert property (clk_high |=> $stable(spi_dout_out))
        else $error("dout moved while serial clock high");
    null_pulse_a: assert property (null_start_out |=> !null_start_out)
        else $error("null start longer than one cycle");
    angle_pulse_a: assert property (angle_wr_out |=> !angle_wr_out)
        else $error("angle write longer than one cycle");
    ready_wait_a: assert property ($fell(sys_rst_in) |-> ##[1:30] ready_out)
        else $error("flash load did not finish");
    ready_keep_a: assert property ((dev_rst_n_in [*6] ##0 ready_out) |=> ready_out)
        else $error("ready dropped without reset");
    line_sel_a: assert property ((misc_control_out[2:0] == 3'b100) [*2]
        |-> !digital_line_2_oe_out) else $error("unselected line driven");
    ctl_hold_a: assert property (quiet |=> $stable(sample_period_out)
        && $stable(misc_control_out)) else $error("control moved without frame");
endmodule // gsri_monitor
bind gsri_top gsri_monitor u_mon (.*);

//--- test/gsri_spi_host.sv
/* spi master model, mode 3, sixteen-bit frames.
   assumes the bench calls xfer one frame at a time. */
`timescale 1ns/1ps
module gsri_spi_host
(
    output reg  spi_clk_out,
    output reg  spi_sel_n_out,
    output reg  spi_din_out,
    input  wire spi_dout_in
);
    // idle: clock high, deselected
    initial {spi_clk_out, spi_sel_n_out, spi_din_out} = 3'b110;
    // msb first; rx taken late in the high phase since dout lags the pin
    task xfer(input [15:0] tx, output [15:0] rx);
        integer k;
        begin
            #1.3 spi_sel_n_out = 1'b0;
            #64;
            for (k = 15; k >= 0; k = k - 1)
            begin
                spi_clk_out = 1'b0;
                spi_din_out = tx[k];
                #16 spi_clk_out = 1'b1; // bench rate; block oversamples
                #15 rx[k] = spi_dout_in;
                #1;
            end
            spi_sel_n_out = 1'b1;
            spi_din_out = ~tx[0]; // released line shows no stale bit
            #9000;
        end
    endtask
endmodule // gsri_spi_host

//--- test/gsri_tb_top.sv
/* self-checking bench for gsri_top.
   assumes gsri_spi_host as master and the bound monitor. */
`timescale 1ns/1ps
module gsri_tb_top;
    reg         ref_clk_in, sys_rst_in, dev_rst_n_in, meas_valid_in, nul_seen;
    reg  [15:0] rate, diag, rx, v, c;
    integer     bad_count, tests_run, i;
    wire        sclk, seln, din, dout, nul, rdy, l1, l1oe;
    wire [15:0] smpl, misc, rng, angw;
    gsri_spi_host host (.spi_clk_out(sclk), .spi_sel_n_out(seln),
        .spi_din_out(din), .spi_dout_in(dout));
    gsri_top dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .spi_clk_in(sclk), .spi_sel_n_in(seln), .spi_din_in(din),
        .spi_dout_out(dout), .spi_dout_oe_out(), .dev_rst_n_in(dev_rst_n_in),
        .meas_supply_in(rate), .meas_rate_in(rate), .meas_analog_in(rate),
        .meas_temp_in(rate), .meas_angle_in(rate), .meas_diag_in(diag),
        .meas_valid_in(meas_valid_in), .lot1_in(rate), .lot2_in(diag),
        .serial_in(rate), .null_start_out(nul), .angle_wr_out(),
        .angle_wr_data_out(angw), .digital_line_1_out(l1), .digital_line_1_oe_out(l1oe),
        .digital_line_2_out(), .digital_line_2_oe_out(), .sample_period_out(smpl),
        .range_and_filter_control_out(rng), .misc_control_out(misc), .ready_out(rdy));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function [15:0] exp_out(input [15:0] r, input [15:0] d);
        exp_out = {1'b1, |d, r[13:0]};
    endfunction
    task fr(input [15:0] tx); host.xfer(tx, rx); endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp)
            begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wait_rdy;
        begin
            repeat (8) @(posedge ref_clk_in);
            for (i = 0; i < 100 && rdy !== 1'b1; i = i + 1) @(posedge ref_clk_in);
            chk({15'h0000, rdy}, 16'h0001);
            repeat (20) @(posedge ref_clk_in);
        end
    endtask
    task give_verdict;
        begin
            if (bad_count == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // clock; watchdog sized well past 24 frames of 9.6 us
    initial
    begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) nul_seen <= sys_rst_in ? 1'b0 : (nul_seen | nul);
    initial
    begin
        #380000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    // main sequence
    initial
    begin
        {sys_rst_in, dev_rst_n_in, meas_valid_in} = 3'b110;
        {bad_count, tests_run, rate, diag} = 0;
        v = $urandom(20);
        v = $urandom;
        repeat (10) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        wait_rdy;
        chk(rng, 16'h0402);
        fr(16'h5700);
        fr(16'h1600); chk(rx, 16'h5a5a);
        fr(16'h3700); chk(rx, 16'h0800);
        fr(16'h3900); chk(rx, 16'h0001);
        fr({8'hb6, v[7:0]}); chk(rx, 16'h0402);
        chk(smpl, {8'h00, v[7:0]});
        fr({8'hb7, v[15:8]}); chk(smpl, v);
        fr(16'hd6ff); // read-only place, write ignored; part code untouched
        fr(16'h5600);
        fr(16'h3600); chk(rx, 16'h5a5a);
        fr(16'h0000); chk(rx, v);
        fr(16'hbe08); c = rx;
        fr(16'h0000);
        fr(16'h8e12); chk(rx, c + 16'h0001);
        chk(angw, 16'h0012);
        fr({8'hb6, ~v[7:0]});
        dev_rst_n_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        dev_rst_n_in <= 1'b1;
        wait_rdy;
        chk(smpl, v);
        fr(16'hbe01); chk({15'h0000, nul_seen}, 16'h0001);
        fr(16'hb404); chk(misc, 16'h0004);
        for (i = 0; i < 3; i = i + 1)
        begin
            @(posedge ref_clk_in);
            rate <= $urandom;
            diag <= $urandom & 16'h0003;
            meas_valid_in <= 1'b1;
            @(posedge ref_clk_in);
            meas_valid_in <= 1'b0;
            repeat (2) @(negedge ref_clk_in);
            chk({14'h0000, l1oe, l1}, 16'h0002);
            fr(i[0] ? 16'h0500 : 16'h0400);
            fr(16'h0000); chk(rx, exp_out(rate, diag));
        end
        fr(16'h0400);
        fr(16'h0000);
        chk(rx, exp_out(rate, diag) & 16'h7fff);
        give_verdict;
    end
endmodule // gsri_tb_top
